// ---- rtl/ppf_pkg.sv ----
// Constants and types for the PHY packet framer and receive queue
package ppf_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_RXQ_CFG   = 8'h30;
    localparam logic [7:0] OFF_NODE_ID   = 8'h34;
    localparam logic [7:0] OFF_PHY_STATE = 8'h38;
    localparam logic [7:0] OFF_TX_FIRST  = 8'h70;
    localparam logic [7:0] OFF_TX_LAST   = 8'h78;
    localparam logic [7:0] OFF_RXQ_READ  = 8'h80;
    // Queue config/status and PHY state field positions
    localparam int CFG_EN_BIT      = 0;
    localparam int CFG_FLUSH_BIT   = 1;
    localparam int CFG_HDR_ERR_BIT = 2;
    localparam int CFG_INV_ERR_BIT = 3;
    localparam int CFG_SPD_ERR_BIT = 4;
    localparam int CFG_EMPTY_BIT   = 5;
    localparam int CFG_FULL_BIT    = 6;
    localparam int CFG_COUNT_LSB   = 8;
    localparam int PHY_FROOT_BIT   = 8;
    localparam int PHY_BUSY_BIT    = 9;
    // Reset values
    localparam logic        CFG_EN_RESET  = 1'b1;
    localparam logic [15:0] NODE_ID_RESET = 16'hffff;
    localparam logic [7:0]  GAP_DEFAULT   = 8'h63;
    // PHY packet marker
    localparam logic [15:0] PHY_MARKER   = 16'h00e0;
    localparam logic [15:0] MARKER_CLEAR = 16'h0000;
    // Packet identifiers and extended types
    localparam logic [1:0] PID_CONFIG  = 2'h0;
    localparam logic [1:0] PID_LINK_ON = 2'h1;
    localparam logic [1:0] PID_SELF_ID = 2'h2;
    localparam logic [3:0] EXT_PING       = 4'h0;
    localparam logic [3:0] EXT_BASE_READ  = 4'h1;
    localparam logic [3:0] EXT_PAGED_READ = 4'h5;
    localparam logic [3:0] EXT_COMMAND    = 4'h8;
    localparam logic [3:0] EXT_RESUME     = 4'hf;
    localparam logic [3:0] PAGED_BASE     = 4'h8;
    // Remote command codes
    localparam logic [2:0] CMD_DISABLE     = 3'h1;
    localparam logic [2:0] CMD_SUSPEND     = 3'h2;
    localparam logic [2:0] CMD_CLEAR_FAULT = 3'h4;
    localparam logic [2:0] CMD_ENABLE      = 3'h5;
    localparam logic [2:0] CMD_RESUME      = 3'h6;
    // Receive queue
    localparam logic [3:0] TCODE_QREAD_REQ  = 4'h4;
    localparam logic [3:0] TCODE_WRITE_RESP = 4'h2;
    localparam logic [1:0] SPD_UNDEF        = 2'h3;
    localparam logic [1:0] DATA_WORD_IDX    = 2'h3;
    // Transmit path states
    typedef enum logic [0:0] {TX_IDLE, TX_SEND} ppf_tx_state_t;
endpackage

// ---- rtl/ppf_top.sv ----
// PHY packet framer, PHY packet decoder and receive queue with APB slave
`timescale 1ns/1ps

module ppf_top import ppf_pkg::*; #(
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Transmit toward PHY interface
    output logic             phy_tx_valid,
    output logic             phy_tx_is_phy,
    output logic [31:0]      phy_tx_q0,
    output logic [31:0]      phy_tx_q1,
    input  wire logic        phy_tx_ready,
    // Received PHY packets
    input  wire logic        rx_valid,
    input  wire logic [31:0] rx_q0,
    input  wire logic [31:0] rx_q1,
    input  wire logic        bus_reset,
    // PHY side effects
    output logic             hdr_err,
    output logic             link_on_evt,
    output logic             self_id_req,
    output logic             reg_read_req,
    output logic [3:0]       reg_read_addr,
    output logic [2:0]       reg_read_page,
    output logic [3:0]       reg_read_port,
    output logic             cmd_confirm,
    output logic [3:0]       cmd_port,
    output logic             port_disable_req,
    output logic             suspend_req,
    output logic             clear_fault_req,
    output logic             port_enable_req,
    output logic             port_resume_req,
    output logic             resume_all,
    output logic             force_root,
    output logic [7:0]       gap_count,
    // Receive queue input stream
    input  wire logic        rxq_valid,
    input  wire logic        rxq_sop,
    input  wire logic        rxq_eop,
    input  wire logic [31:0] rxq_data,
    input  wire logic [3:0]  rxq_status,
    input  wire logic [1:0]  rxq_spd,
    input  wire logic [3:0]  rxq_ack,
    input  wire logic [3:0]  rxq_tcode,
    input  wire logic        rxq_for_agent,
    output logic             rxq_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    // Addressed-to-this-node check on the Dest_phy_node_id field
    function automatic logic addressed(input logic [31:0] q, input logic [5:0] id);
        addressed = (q[29:24] == id);
    endfunction
    logic [15:0]   node_id;
    logic          q_en;
    logic          err_hdr;
    logic          err_inv;
    logic          err_spd;
    logic [31:0]   tx_first;
    ppf_tx_state_t tx_state;
    logic [31:0]   mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [CW-1:0] count;
    logic          tok_done;
    logic [1:0]    widx;
    logic [1:0]    resets_seen;

    // Bus decode
    logic setup;
    logic acc;
    logic wr;
    logic rd;
    logic mapped;
    assign setup  = psel & ~penable;
    assign acc    = psel & penable;
    assign wr     = acc & pwrite;
    assign rd     = acc & ~pwrite;
    assign mapped = (paddr == OFF_RXQ_CFG) | (paddr == OFF_NODE_ID) | (paddr == OFF_PHY_STATE) |
                    (paddr == OFF_TX_FIRST) | (paddr == OFF_TX_LAST) | (paddr == OFF_RXQ_READ);
    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;
    // Queue status terms
    logic empty;
    logic full;
    logic pop;
    logic flush;
    assign empty = (count == '0);
    assign full  = (count == CW'(DEPTH));
    assign pop   = rd & (paddr == OFF_RXQ_READ) & ~empty;
    assign flush = wr & (paddr == OFF_RXQ_CFG) & pwdata[CFG_FLUSH_BIT];
    // Read data captured in setup phase
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            prdata <= 32'h0000_0000;
            case (paddr)
                OFF_RXQ_CFG: begin
                    prdata[CFG_EN_BIT]      <= q_en;
                    prdata[CFG_HDR_ERR_BIT] <= err_hdr;
                    prdata[CFG_INV_ERR_BIT] <= err_inv;
                    prdata[CFG_SPD_ERR_BIT] <= err_spd;
                    prdata[CFG_EMPTY_BIT]   <= empty;
                    prdata[CFG_FULL_BIT]    <= full;
                    prdata[CFG_COUNT_LSB +: CW] <= count;
                end
                OFF_NODE_ID:   prdata[15:0] <= node_id;
                OFF_PHY_STATE: begin
                    prdata[7:0]           <= gap_count;
                    prdata[PHY_FROOT_BIT] <= force_root;
                    prdata[PHY_BUSY_BIT]  <= (tx_state == TX_SEND);
                end
                OFF_RXQ_READ:  prdata <= empty ? 32'h0000_0000 : mem[rptr];
                default:       prdata <= 32'h0000_0000;
            endcase
        end
    end
    // Software control registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q_en    <= CFG_EN_RESET;
            node_id <= NODE_ID_RESET;
        end else if (wr) begin
            if (paddr == OFF_RXQ_CFG) q_en <= pwdata[CFG_EN_BIT];
            if (paddr == OFF_NODE_ID) node_id <= pwdata[15:0];
        end
    end
    // Transmit path: first quadlet held, second launches
    logic tx_launch;
    assign tx_launch = wr & (paddr == OFF_TX_LAST) & (tx_state == TX_IDLE);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_first      <= 32'h0000_0000;
            tx_state      <= TX_IDLE;
            phy_tx_valid  <= 1'b0;
            phy_tx_is_phy <= 1'b0;
            phy_tx_q0     <= 32'h0000_0000;
            phy_tx_q1     <= 32'h0000_0000;
        end else begin
            // First quadlet captured at its offset
            if (wr && paddr == OFF_TX_FIRST && tx_state == TX_IDLE) tx_first <= pwdata;
            case (tx_state)
                TX_IDLE: begin
                    if (tx_launch) begin
                        tx_state     <= TX_SEND;
                        phy_tx_valid <= 1'b1;
                        phy_tx_q1    <= pwdata;
                        phy_tx_is_phy <= (tx_first[15:0] == PHY_MARKER);
                        phy_tx_q0 <= (tx_first[15:0] == PHY_MARKER) ?
                                     {tx_first[31:16], MARKER_CLEAR} : tx_first;
                    end
                end
                TX_SEND: begin
                    if (phy_tx_ready) begin
                        tx_state     <= TX_IDLE;
                        phy_tx_valid <= 1'b0;
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    // Received PHY packet classification
    logic rx_good;
    logic is_cfg;
    logic is_ext;
    logic for_us;
    logic [3:0] ext_type;
    logic [2:0] cmnd;
    assign rx_good  = rx_valid & (rx_q1 == ~rx_q0);
    assign is_cfg   = rx_good & (rx_q0[31:30] == PID_CONFIG) & (rx_q0[23] | rx_q0[22]);
    assign is_ext   = rx_good & (rx_q0[31:30] == PID_CONFIG) & ~rx_q0[23] & ~rx_q0[22];
    assign for_us   = addressed(rx_q0, node_id[5:0]);
    assign ext_type = rx_q0[19:16];
    assign cmnd     = rx_q0[2:0];

    // Force-root and gap count state
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            force_root  <= 1'b0;
            gap_count   <= GAP_DEFAULT;
            resets_seen <= 2'h0;
        end else begin
            // Only the selected root keeps force-root
            if (is_cfg && rx_q0[23]) force_root <= for_us;
            if (is_cfg && rx_q0[22]) begin
                gap_count   <= {2'h0, rx_q0[21:16]};
                resets_seen <= 2'h0;
            end else if (bus_reset) begin
                if (resets_seen != 2'h0) gap_count <= GAP_DEFAULT;
                else resets_seen <= 2'h1;
            end
        end
    end

    // PHY event pulses
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hdr_err          <= 1'b0;
            link_on_evt      <= 1'b0;
            self_id_req      <= 1'b0;
            reg_read_req     <= 1'b0;
            reg_read_addr    <= 4'h0;
            reg_read_page    <= 3'h0;
            reg_read_port    <= 4'h0;
            cmd_confirm      <= 1'b0;
            cmd_port         <= 4'h0;
            port_disable_req <= 1'b0;
            suspend_req      <= 1'b0;
            clear_fault_req  <= 1'b0;
            port_enable_req  <= 1'b0;
            port_resume_req  <= 1'b0;
            resume_all       <= 1'b0;
        end else begin
            // False header error on id match
            hdr_err <= rx_good & (rx_q0[31:30] == PID_CONFIG) & (rx_q0[31:16] == node_id);
            link_on_evt <= rx_good & (rx_q0[31:30] == PID_LINK_ON) & for_us;
            self_id_req <= is_ext & for_us & (ext_type == EXT_PING);
            reg_read_req <= is_ext & for_us & ((ext_type == EXT_BASE_READ) | (ext_type == EXT_PAGED_READ));
            if (is_ext && for_us) begin
                reg_read_addr <= (ext_type == EXT_PAGED_READ) ? (PAGED_BASE + {1'b0, rx_q0[8:6]})
                                                              : {1'b0, rx_q0[8:6]};
                reg_read_page <= rx_q0[15:13];
                reg_read_port <= rx_q0[12:9];
                cmd_port      <= rx_q0[12:9];
            end
            cmd_confirm <= is_ext & for_us & (ext_type == EXT_COMMAND);
            port_disable_req <= is_ext & for_us & (ext_type == EXT_COMMAND) & (cmnd == CMD_DISABLE);
            suspend_req      <= is_ext & for_us & (ext_type == EXT_COMMAND) & (cmnd == CMD_SUSPEND);
            clear_fault_req  <= is_ext & for_us & (ext_type == EXT_COMMAND) & (cmnd == CMD_CLEAR_FAULT);
            port_enable_req  <= is_ext & for_us & (ext_type == EXT_COMMAND) & (cmnd == CMD_ENABLE);
            port_resume_req  <= is_ext & for_us & (ext_type == EXT_COMMAND) & (cmnd == CMD_RESUME);
            resume_all <= is_ext & (ext_type == EXT_RESUME);
        end
    end

    // Receive queue write side
    logic tok_wr;
    logic word_acc;
    logic skip;
    logic push;
    // Agent packets are accepted and dropped
    assign tok_wr   = q_en & rxq_valid & rxq_sop & ~tok_done & ~rxq_for_agent & ~full;
    assign rxq_ready = q_en & (rxq_for_agent | (~full & (~rxq_sop | tok_done)));
    assign word_acc = rxq_valid & rxq_ready;
    // Data quadlet omitted for these codes
    assign skip = rxq_for_agent | ((widx == DATA_WORD_IDX) &
                  ((rxq_tcode == TCODE_QREAD_REQ) | (rxq_tcode == TCODE_WRITE_RESP)));
    assign push = tok_wr | (word_acc & ~skip);

    // Queue storage and pointers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wptr     <= '0;
            rptr     <= '0;
            count    <= '0;
            tok_done <= 1'b0;
            widx     <= 2'h0;
        end else if (flush) begin
            wptr     <= '0;
            rptr     <= '0;
            count    <= '0;
            tok_done <= 1'b0;
            widx     <= 2'h0;
        end else begin
            if (tok_wr) tok_done <= 1'b1;
            if (word_acc) begin
                widx <= rxq_eop ? 2'h0 : ((widx == 2'h3) ? widx : widx + 2'h1);
                if (rxq_eop) tok_done <= 1'b0;
            end
            if (push) wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + AW'(1);
            if (pop) rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + AW'(1);
            count <= count + CW'(push) - CW'(pop);
        end
    end

    // Queue memory: token or received packet word
    always_ff @(posedge clk) begin
        if (push && !flush) begin
            // Token: status, speed, ack; speed code kept
            mem[wptr] <= tok_wr ? {rxq_status, 10'h000, rxq_spd, 12'h000, rxq_ack} : rxq_data;
        end
    end

    // Sticky error flags, set beats clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            err_hdr <= 1'b0;
            err_inv <= 1'b0;
            err_spd <= 1'b0;
        end else begin
            err_hdr <= hdr_err | (err_hdr & ~(wr && paddr == OFF_RXQ_CFG && pwdata[CFG_HDR_ERR_BIT]));
            err_inv <= (rx_valid & ~rx_good) |
                       (err_inv & ~(wr && paddr == OFF_RXQ_CFG && pwdata[CFG_INV_ERR_BIT]));
            err_spd <= (tok_wr & (rxq_spd == SPD_UNDEF)) |
                       (err_spd & ~(wr && paddr == OFF_RXQ_CFG && pwdata[CFG_SPD_ERR_BIT]));
        end
    end

    // Assertions
    // Marker cleared
    a_tx_marker_zero: assert property (@(posedge clk) disable iff (!rst_b)
        phy_tx_valid && phy_tx_is_phy |-> phy_tx_q0[15:0] == MARKER_CLEAR)
        else $error("marker not cleared");
    a_tx_launch_phy: assert property (@(posedge clk) disable iff (!rst_b)
        tx_launch && tx_first[15:0] == PHY_MARKER |=> phy_tx_valid && phy_tx_is_phy && phy_tx_q1 == $past(pwdata))
        else $error("PHY packet not launched");
    a_hdr_err_pulse: assert property (@(posedge clk) disable iff (!rst_b)
        rx_good && rx_q0[31:30] == PID_CONFIG && rx_q0[31:16] == node_id |=> hdr_err)
        else $error("header error missing");
    a_inv_discard: assert property (@(posedge clk) disable iff (!rst_b)
        rx_valid && rx_q1 != ~rx_q0 |=> !link_on_evt && !self_id_req && !cmd_confirm && !hdr_err)
        else $error("bad packet acted on");
    a_force_root_sel: assert property (@(posedge clk) disable iff (!rst_b)
        is_cfg && rx_q0[23] |=> force_root == ($past(rx_q0[29:24]) == node_id[5:0]))
        else $error("force root wrong");
    a_gap_load: assert property (@(posedge clk) disable iff (!rst_b)
        is_cfg && rx_q0[22] |=> gap_count == {2'h0, $past(rx_q0[21:16])})
        else $error("gap not loaded");
    // Gap survives one reset, restored after second
    a_gap_restore: assert property (@(posedge clk) disable iff (!rst_b)
        bus_reset && resets_seen != 2'h0 && !(is_cfg && rx_q0[22]) |=> gap_count == GAP_DEFAULT)
        else $error("gap not restored");
    a_reserved_cfg: assert property (@(posedge clk) disable iff (!rst_b)
        is_ext && !bus_reset |=> $stable(gap_count) && $stable(force_root))
        else $error("reserved config acted on");
    a_ping_selfid: assert property (@(posedge clk) disable iff (!rst_b)
        is_ext && for_us && ext_type == EXT_PING |=> self_id_req)
        else $error("ping not answered");
    a_rxq_skip: assert property (@(posedge clk) disable iff (!rst_b)
        word_acc && skip && !pop && !flush |=> count == $past(count))
        else $error("skipped word stored");
    c_phy_send: cover property (@(posedge clk) disable iff (!rst_b) phy_tx_valid && phy_tx_is_phy && phy_tx_ready);
    c_link_on:  cover property (@(posedge clk) disable iff (!rst_b) link_on_evt);
    c_rxq_read: cover property (@(posedge clk) disable iff (!rst_b) pop);
    c_remote:   cover property (@(posedge clk) disable iff (!rst_b) reg_read_req ##[1:20] cmd_confirm);
endmodule // ppf_top

// ---- verification/ppf_phy_model.sv ----
// PHY interface model that takes transmitted packets after a stall
`timescale 1ns/1ps
module ppf_phy_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Packet handshake
    input  wire logic        phy_tx_valid,
    input  wire logic [31:0] phy_tx_q0,
    input  wire logic [31:0] phy_tx_q1,
    input  wire logic [3:0]  stall,
    output logic             phy_tx_ready,
    output logic [31:0]      got_q0,
    output logic [31:0]      got_q1
);
    logic [3:0] wait_cnt;
    // Ready only once the chosen stall has run out
    assign phy_tx_ready = phy_tx_valid && (wait_cnt >= stall);
    // Stall counter and capture of each accepted packet
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_cnt <= 4'h0;
            got_q0   <= 32'h0;
            got_q1   <= 32'h0;
        end else if (phy_tx_ready) begin
            wait_cnt <= 4'h0;
            got_q0   <= phy_tx_q0;
            got_q1   <= phy_tx_q1;
        end else if (phy_tx_valid) begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule // ppf_phy_model

// ---- verification/ppf_top_tb.sv ----
// Self-checking bench for the PHY packet framer
`timescale 1ns/1ps
module ppf_top_tb;
    import ppf_pkg::*;
    logic clk, rst_b, psel, penable, pwrite, pready, pslverr, phy_tx_valid, phy_tx_is_phy, phy_tx_ready;
    logic rx_valid, bus_reset, hdr_err, link_on_evt, self_id_req, reg_read_req, cmd_confirm;
    logic port_disable_req, suspend_req, clear_fault_req, port_enable_req, port_resume_req, resume_all;
    logic force_root, rxq_valid, rxq_sop, rxq_eop, rxq_for_agent, rxq_ready;
    logic [7:0]  paddr, gap_count;
    logic [31:0] pwdata, prdata, phy_tx_q0, phy_tx_q1, rx_q0, rx_q1, rxq_data, got_q0, got_q1, rd;
    logic [3:0]  reg_read_addr, reg_read_port, cmd_port, rxq_status, rxq_ack, rxq_tcode, stall;
    logic [2:0]  reg_read_page;
    logic [1:0]  rxq_spd;
    logic        er;
    int          num_errors, check_count;
    ppf_top #(.DEPTH(16)) DUT (.*);
    ppf_phy_model phy (.*);
    // Clock, idle inputs and reset
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    initial begin
        {rst_b, psel, penable, pwrite, rx_valid, bus_reset, rxq_valid, rxq_sop, rxq_eop, rxq_for_agent} = 0;
        {paddr, pwdata, rx_q0, rx_q1, rxq_data, rxq_status, rxq_spd, rxq_ack, rxq_tcode} = 0;
        stall = 4'h3;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        t_regs;
        t_tx;
        t_config;
        t_ext;
        t_queue;
        t_hdr;
        wrap_up;
    end
    // Watchdog against a hang
    initial begin
        #200000;
        num_errors++;
        wrap_up;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        // Wait for pready; only the watchdog ends a hang
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task rx(input logic [31:0] q0, input logic [31:0] q1);
        @(posedge clk);
        {rx_valid, rx_q0, rx_q1} <= {1'b1, q0, q1};
        @(posedge clk);
        rx_valid <= 1'b0;
        @(negedge clk);
    endtask
    task breset;
        @(posedge clk);
        bus_reset <= 1'b1;
        @(posedge clk);
        bus_reset <= 1'b0;
        @(negedge clk);
    endtask
    task t_regs;
        apb(1'b0, OFF_RXQ_CFG, 32'h0);
        chk(rd, 32'h21);
        apb(1'b0, OFF_PHY_STATE, 32'h0);
        chk(rd, 32'h63);
        apb(1'b0, 8'h40, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
    endtask
    task t_tx;
        apb(1'b1, OFF_TX_FIRST, 32'h3fc0_00e0);
        apb(1'b1, OFF_TX_LAST, ~32'h3fc0_00e0);
        do @(negedge clk); while (phy_tx_valid !== 1'b1);
        chk(phy_tx_is_phy, 1'b1);
        do @(negedge clk); while (phy_tx_valid !== 1'b0);
        chk(got_q0, 32'h3fc0_0000);
        chk(got_q1, ~32'h3fc0_00e0);
    endtask
    task t_config;
        rx(32'h3fea_0000, ~32'h3fea_0000);
        chk({force_root, gap_count}, 9'h12a);
        rx(32'h3f00_0000, ~32'h3f00_0000);
        chk({force_root, gap_count, self_id_req}, 10'h255);
        rx(32'h0580_0000, ~32'h0580_0000);
        chk({force_root, gap_count}, 9'h02a);
        rx(32'h3fc0_0000, 32'h0);
        chk(force_root, 1'b0);
        breset;
        chk(gap_count, 8'h2a);
        breset;
        chk(gap_count, GAP_DEFAULT);
    endtask
    task t_ext;
        rx(32'h7f00_0000, ~32'h7f00_0000);
        chk(link_on_evt, 1'b1);
        rx(32'h3f05_4780, ~32'h3f05_4780);
        chk({reg_read_req, reg_read_addr, reg_read_page, reg_read_port}, 12'hf23);
        rx(32'h3f01_00c0, ~32'h3f01_00c0);
        chk({reg_read_req, reg_read_addr}, 5'h13);
        for (int c = 0; c < 7; c++) begin
            rx(32'h3f08_0400 | c, ~(32'h3f08_0400 | c));
            chk({port_disable_req, suspend_req, clear_fault_req, port_enable_req, port_resume_req},
                {c == 1, c == 2, c == 4, c == 5, c == 6});
            chk(cmd_port, 4'h2);
            chk(cmd_confirm, 1'b1);
        end
        rx(32'h000f_0000, ~32'h000f_0000);
        chk(resume_all, 1'b1);
    endtask
    task push(input logic [31:0] d, input logic s, input logic e);
        @(posedge clk);
        {rxq_valid, rxq_sop, rxq_eop, rxq_data} <= {1'b1, s, e, d};
        do @(negedge clk); while (rxq_ready !== 1'b1);
        @(posedge clk);
        rxq_valid <= 1'b0;
    endtask
    task t_queue;
        @(posedge clk);
        {rxq_status, rxq_spd, rxq_ack, rxq_tcode} <= {4'h1, 2'h2, 4'h1, TCODE_QREAD_REQ};
        push(32'h3f00_0140, 1'b1, 1'b0);
        push(32'hffc1_ffff, 1'b0, 1'b0);
        push(32'hf000_0400, 1'b0, 1'b0);
        push(32'hdead_beef, 1'b0, 1'b1);
        apb(1'b0, OFF_RXQ_READ, 32'h0);
        chk(rd, 32'h1002_0001);
        apb(1'b0, OFF_RXQ_READ, 32'h0);
        chk(rd, 32'h3f00_0140);
        apb(1'b0, OFF_RXQ_READ, 32'h0);
        chk(rd, 32'hffc1_ffff);
        apb(1'b0, OFF_RXQ_READ, 32'h0);
        chk(rd, 32'hf000_0400);
        apb(1'b0, OFF_RXQ_READ, 32'h0);
        chk(rd, 32'h0);
        // Agent packet is consumed but never stored
        rxq_for_agent <= 1'b1;
        push(32'h1234_5678, 1'b1, 1'b1);
        rxq_for_agent <= 1'b0;
        apb(1'b0, OFF_RXQ_READ, 32'h0);
        chk(rd, 32'h0);
    endtask
    task t_hdr;
        apb(1'b1, OFF_NODE_ID, 32'h3fc0);
        rx(32'h3fc0_0000, ~32'h3fc0_0000);
        chk(hdr_err, 1'b1);
        // Sticky header and inverse flags, then write-one clear
        apb(1'b0, OFF_RXQ_CFG, 32'h0);
        chk(rd, 32'h2d);
        apb(1'b1, OFF_RXQ_CFG, 32'h0d);
        apb(1'b0, OFF_RXQ_CFG, 32'h0);
        chk(rd, 32'h21);
    endtask
endmodule // ppf_top_tb
